// ==== logic/saeic_top.sv ====
// Sleep mode control and external interrupt sensing with an Avalon-MM slave.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module saeic_top (
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        RESET,
   // Avalon-MM slave.
   input  wire logic [9:0]  ADDRESS,
   input  wire logic [3:0]  BYTEENABLE,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   output logic [31:0]      READDATA,
   output logic             WAITREQUEST,
   // Core handshake.
   input  wire logic        HALT_EXEC,
   input  wire logic        INSTR_DONE,
   input  wire logic        IRQ_ACK_A,
   input  wire logic        IRQ_ACK_B,
   // Wake sources.
   input  wire logic        EXT_IRQ_PIN_A,
   input  wire logic        EXT_IRQ_PIN_B,
   input  wire logic        INT_IRQ_PEND,
   input  wire logic        COMP_IRQ,
   input  wire logic        T2_OVF_IRQ,
   input  wire logic        T2_CMP_IRQ,
   // Interrupt requests to the core.
   output logic             IRQ_TAKE_A,
   output logic             IRQ_TAKE_B,
   // Clock and power controls.
   output logic             CPU_CLK_EN,
   output logic             PERIPH_CLK_EN,
   output logic             OSC_EN,
   output logic             COMP_PWR_EN,
   output logic             T2_ASYNC_RUN
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   saeic_pkg::saeic_state_t state;       // Present power state.
   saeic_pkg::saeic_state_t next_state;  // Next power state.
   logic [6:0]  mcu_control;             // Sleep and sense control bits.
   logic [6:0]  aux_control;             // Enables and masks mirrored here.
   logic        ack;                     // Bus answer cycle.
   logic [11:0] start_cnt;               // Start-up delay countdown.
   logic [11:0] next_start_cnt;          // Next countdown value.
   logic [1:0]  hold_cnt;                // Instructions left with flags hidden.
   logic        from_psave;              // Start-up began in power save.
   logic        by_timer;                // Power save wake came from the timer.
   logic        req_a;                   // Raw request of the first pin.
   logic        req_b;                   // Raw request of the second pin.
   logic        lvl_a;                   // Synchronised first pin.
   logic        lvl_b;                   // Synchronised second pin.
   wire [7:0]   idx_ctrl  = saeic_pkg::IDX_MCU_CONTROL;  // Control register index.
   wire [7:0]   idx_aux   = saeic_pkg::IDX_AUX_CONTROL;  // Auxiliary register index.
   wire [7:0]   idx_stat  = saeic_pkg::IDX_STATUS;       // Status register index.
   wire         bus_req   = READ | WRITE;
   wire         sel_ctrl  = ADDRESS == {idx_ctrl, 2'h0};
   wire         sel_aux   = ADDRESS == {idx_aux, 2'h0};
   wire         sel_stat  = ADDRESS == {idx_stat, 2'h0};
   wire         wr_ok     = WRITE & ack & BYTEENABLE[0];
   // Control fields.
   wire         sleep_arm = mcu_control[saeic_pkg::SLEEP_ARM_BIT];
   wire [1:0]   sleep_sel = {mcu_control[saeic_pkg::SLEEP_SEL_HI],
                             mcu_control[saeic_pkg::SLEEP_SEL_LO]};
   wire [1:0]   sense_b   = {mcu_control[saeic_pkg::EXT_IRQ_PIN_B_SENSE_HI],
                             mcu_control[saeic_pkg::EXT_IRQ_PIN_B_SENSE_LO]};
   wire [1:0]   sense_a   = {mcu_control[saeic_pkg::EXT_IRQ_PIN_A_SENSE_HI],
                             mcu_control[saeic_pkg::EXT_IRQ_PIN_A_SENSE_LO]};
   wire         gie       = aux_control[saeic_pkg::AUX_GIE_BIT];
   wire         mask_a    = aux_control[saeic_pkg::AUX_MASK_A_BIT];
   wire         mask_b    = aux_control[saeic_pkg::AUX_MASK_B_BIT];
   wire         comp_dis  = aux_control[saeic_pkg::AUX_COMP_DIS_BIT];
   wire         async_sel = aux_control[saeic_pkg::AUX_ASYNC_BIT];
   wire         t2_ovf_en = aux_control[saeic_pkg::AUX_T2_OVF_BIT];
   wire         t2_cmp_en = aux_control[saeic_pkg::AUX_T2_CMP_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Pin sensing.

   saeic_pin_sense u_pin_a (
      .clk   (CLK),
      .reset (RESET),
      .pin   (EXT_IRQ_PIN_A),
      .sense (sense_a),
      .ack   (IRQ_ACK_A),
      .req   (req_a),
      .level (lvl_a)
   );

   saeic_pin_sense u_pin_b (
      .clk   (CLK),
      .reset (RESET),
      .pin   (EXT_IRQ_PIN_B),
      .sense (sense_b),
      .ack   (IRQ_ACK_B),
      .req   (req_b),
      .level (lvl_b)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Wake and take decisions.

   wire en_a     = req_a & gie & mask_a;
   wire en_b     = req_b & gie & mask_b;
   wire lvl_en_a = en_a & (sense_a == saeic_pkg::SENSE_LOW);
   wire lvl_en_b = en_b & (sense_b == saeic_pkg::SENSE_LOW);
   wire comp_wake = COMP_IRQ & ~comp_dis;
   wire wake_idle = en_a | en_b | INT_IRQ_PEND | comp_wake;
   wire wake_pd   = lvl_en_a | lvl_en_b;
   wire timer_wake = async_sel & ((T2_OVF_IRQ & t2_ovf_en) | (T2_CMP_IRQ & t2_cmp_en));
   wire wake_ps   = wake_pd | timer_wake;
   wire hold      = hold_cnt != 2'h0;
   wire start_done = start_cnt == 12'h000;

   assign IRQ_TAKE_A = (state == saeic_pkg::ST_RUN) & en_a & ~hold;
   assign IRQ_TAKE_B = (state == saeic_pkg::ST_RUN) & en_b & ~hold;

   ////////////////////////////////////////////////////////////////////////////////
   // Power state machine.

   // Next state and start-up countdown.
   always_comb begin
      next_state     = state;
      next_start_cnt = start_cnt;
      case (state)
         saeic_pkg::ST_RUN: begin
            if (HALT_EXEC && sleep_arm) begin
               case (sleep_sel)
                  saeic_pkg::SLEEP_IDLE:  next_state = saeic_pkg::ST_IDLE;
                  saeic_pkg::SLEEP_PDOWN: next_state = saeic_pkg::ST_PDOWN;
                  saeic_pkg::SLEEP_PSAVE: next_state = saeic_pkg::ST_PSAVE;
                  default:                next_state = saeic_pkg::ST_RUN;
               endcase
            end
         end
         saeic_pkg::ST_IDLE: begin
            if (wake_idle) begin
               next_state = saeic_pkg::ST_RUN;
            end
         end
         saeic_pkg::ST_PDOWN: begin
            if (wake_pd) begin
               next_state     = saeic_pkg::ST_STARTUP;
               next_start_cnt = saeic_pkg::STARTUP_CYCLES;
            end
         end
         saeic_pkg::ST_PSAVE: begin
            if (wake_ps) begin
               next_state     = saeic_pkg::ST_STARTUP;
               next_start_cnt = saeic_pkg::STARTUP_CYCLES;
            end
         end
         saeic_pkg::ST_STARTUP: begin
            if (start_done) begin
               next_state = saeic_pkg::ST_RUN;
            end else begin
               next_start_cnt = start_cnt - 12'h001;
            end
         end
         default: begin
            next_state = saeic_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state     <= saeic_pkg::ST_RUN;
         start_cnt <= 12'h000;
      end else begin
         state     <= next_state;
         start_cnt <= next_start_cnt;
      end
   end

   // Remember where start-up began and what woke power save.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         from_psave <= 1'b0;
         by_timer   <= 1'b0;
      end else if (state == saeic_pkg::ST_PSAVE && wake_ps) begin
         from_psave <= 1'b1;
         by_timer   <= timer_wake & ~wake_pd;
      end else if (state == saeic_pkg::ST_PDOWN && wake_pd) begin
         from_psave <= 1'b0;
         by_timer   <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         hold_cnt <= 2'h0;
      end else if (state == saeic_pkg::ST_STARTUP && start_done && from_psave) begin
         hold_cnt <= by_timer ? saeic_pkg::HOLD_TIMER_INSTR : saeic_pkg::HOLD_EXT_INSTR;
      end else if (INSTR_DONE && hold) begin
         hold_cnt <= hold_cnt - 2'h1;
      end
   end

   assign CPU_CLK_EN    = state == saeic_pkg::ST_RUN;
   assign PERIPH_CLK_EN = (state == saeic_pkg::ST_RUN) | (state == saeic_pkg::ST_IDLE);
   assign OSC_EN        = (state != saeic_pkg::ST_PDOWN) & (state != saeic_pkg::ST_PSAVE);
   assign COMP_PWR_EN   = ~comp_dis;
   assign T2_ASYNC_RUN  = async_sel & ((state == saeic_pkg::ST_PSAVE) | OSC_EN);

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave.

   // One wait cycle, then the answer cycle.
   assign WAITREQUEST = bus_req & ~ack;

   // Answer cycle marker.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ack <= 1'b0;
      end else begin
         ack <= bus_req & ~ack;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         mcu_control <= saeic_pkg::MCU_CONTROL_RESET;
         aux_control <= saeic_pkg::AUX_CONTROL_RESET;
      end else if (wr_ok && sel_ctrl) begin
         mcu_control <= WRITEDATA[6:0];
      end else if (wr_ok && sel_aux) begin
         aux_control <= WRITEDATA[6:0];
      end
   end

   // Status word shown to software.
   wire [4:0] status_word = {hold,
                             req_b & ~hold,
                             req_a & ~hold,
                             state == saeic_pkg::ST_STARTUP,
                             ~CPU_CLK_EN};
   wire [31:0] rd_mux = sel_ctrl ? {25'h0000000, mcu_control} :
                        sel_aux  ? {25'h0000000, aux_control} :
                        sel_stat ? {27'h0000000, status_word} : 32'h00000000;

   // Read data loaded as the answer cycle starts.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         READDATA <= 32'h00000000;
      end else if (READ && !ack) begin
         READDATA <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_sleep_arm: assert property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_RUN && HALT_EXEC && !sleep_arm |=> state == saeic_pkg::ST_RUN)
      else $error("halt slept without arm");
   a_sleep_select: assert property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_RUN && HALT_EXEC && sleep_arm &&
      sleep_sel == saeic_pkg::SLEEP_PDOWN |=> state == saeic_pkg::ST_PDOWN && !OSC_EN)
      else $error("power-down not entered");
   a_rsvd_sleep: assert property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_RUN && HALT_EXEC && sleep_sel == saeic_pkg::SLEEP_RSVD
      |=> CPU_CLK_EN)
      else $error("reserved select slept");
   a_take_masked: assert property (@(posedge CLK) disable iff (RESET)
      (IRQ_TAKE_A || IRQ_TAKE_B) |-> gie && (!IRQ_TAKE_A || mask_a) && (!IRQ_TAKE_B || mask_b))
      else $error("interrupt taken while masked");
   a_idle_wake: assert property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_IDLE && wake_idle |=> CPU_CLK_EN)
      else $error("idle wake delayed");
   a_idle_clocks: assert property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_IDLE |-> !CPU_CLK_EN && PERIPH_CLK_EN && OSC_EN)
      else $error("idle clocks wrong");
   a_startup_wait: assert property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_STARTUP && !start_done |=> !CPU_CLK_EN)
      else $error("start-up cut short");
   a_timer_wake: assert property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_PSAVE && timer_wake && !gie
      |=> state == saeic_pkg::ST_STARTUP && start_cnt == saeic_pkg::STARTUP_CYCLES)
      else $error("timer did not wake power save");
   a_hold_flags: assert property (@(posedge CLK) disable iff (RESET)
      $rose(CPU_CLK_EN) && from_psave |-> hold ##0 !IRQ_TAKE_A && !IRQ_TAKE_B)
      else $error("flags visible too early");
   a_ctrl_bit7: assert property (@(posedge CLK) disable iff (RESET)
      READ && ack |-> READDATA[31:7] == 25'h0000000)
      else $error("reserved read bits not zero");
   c_idle_cycle: cover property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_IDLE ##1 state == saeic_pkg::ST_RUN);
   c_pdown_wake: cover property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_STARTUP && start_done && !from_psave);
   c_psave_timer: cover property (@(posedge CLK) disable iff (RESET)
      state == saeic_pkg::ST_PSAVE && timer_wake);
   c_take_a: cover property (@(posedge CLK) disable iff (RESET) IRQ_TAKE_A);
endmodule

// ==== logic/saeic_pkg.sv ====
// Constants shared by the sleep and external interrupt control logic.
package saeic_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_MCU_CONTROL = 8'h35;
   localparam logic [7:0] IDX_AUX_CONTROL = 8'h36;
   localparam logic [7:0] IDX_STATUS      = 8'h37;
   // Control register field positions.
   localparam int SLEEP_ARM_BIT  = 6;
   localparam int SLEEP_SEL_HI   = 5;
   localparam int SLEEP_SEL_LO   = 4;
   localparam int EXT_IRQ_PIN_B_SENSE_HI  = 3;
   localparam int EXT_IRQ_PIN_B_SENSE_LO  = 2;
   localparam int EXT_IRQ_PIN_A_SENSE_HI  = 1;
   localparam int EXT_IRQ_PIN_A_SENSE_LO  = 0;
   localparam logic [6:0] MCU_CONTROL_RESET = 7'h00;
   // Auxiliary control field positions.
   localparam int AUX_GIE_BIT      = 0;
   localparam int AUX_MASK_A_BIT   = 1;
   localparam int AUX_MASK_B_BIT   = 2;
   localparam int AUX_COMP_DIS_BIT = 3;
   localparam int AUX_ASYNC_BIT    = 4;
   localparam int AUX_T2_OVF_BIT   = 5;
   localparam int AUX_T2_CMP_BIT   = 6;
   localparam logic [6:0] AUX_CONTROL_RESET = 7'h00;
   // Status field positions.
   localparam int ST_SLEEPING_BIT = 0;
   localparam int ST_STARTUP_BIT  = 1;
   localparam int ST_REQ_A_BIT    = 2;
   localparam int ST_REQ_B_BIT    = 3;
   localparam int ST_HOLD_BIT     = 4;
   // Sleep select encodings.
   localparam logic [1:0] SLEEP_IDLE  = 2'h0;
   localparam logic [1:0] SLEEP_RSVD  = 2'h1;
   localparam logic [1:0] SLEEP_PDOWN = 2'h2;
   localparam logic [1:0] SLEEP_PSAVE = 2'h3;
   // Pin sense encodings.
   localparam logic [1:0] SENSE_LOW  = 2'h0;
   localparam logic [1:0] SENSE_RSVD = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   // Instructions that run before flags become visible after power save.
   localparam logic [1:0] HOLD_EXT_INSTR   = 2'h2;
   localparam logic [1:0] HOLD_TIMER_INSTR = 2'h3;
   // Start-up delay after power-down, equal to the reset delay period.
   localparam int CLK_PERIOD_NS  = 25;
   localparam int RESET_DELAY_NS = 100000;
   localparam int STARTUP_CYCLES_I = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] STARTUP_CYCLES = STARTUP_CYCLES_I[11:0];
   // Power state of the controller.
   typedef enum logic [2:0] {
      ST_RUN, ST_IDLE, ST_PDOWN, ST_PSAVE, ST_STARTUP
   } saeic_state_t;
endpackage

// ==== logic/saeic_pin_sense.sv ====
// One external interrupt pin: synchroniser, edge detector and request flag.
`timescale 1ns/1ps
module saeic_pin_sense (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset,
   // Raw pin and its sense mode.
   input  wire logic       pin,
   input  wire logic [1:0] sense,
   // Acknowledge from vectoring, clears an edge request.
   input  wire logic       ack,
   // Request and synchronised pin level.
   output logic            req,
   output logic            level
);
   logic sync1;   // First synchroniser stage, read only by sync2.
   logic sync2;   // Second synchroniser stage.
   logic prev;    // Previous synchronised level for edge detection.
   logic flag;    // Sticky edge request.
   logic fall;    // Falling edge seen this cycle.
   logic rise;    // Rising edge seen this cycle.
   logic edge_hit; // Edge matching the selected mode.

   assign fall     = prev & ~sync2;
   assign rise     = ~prev & sync2;
   assign edge_hit = ((sense == saeic_pkg::SENSE_FALL) & fall) |
                     ((sense == saeic_pkg::SENSE_RISE) & rise);

   // Pin sampled by two flip-flops, then a third for the previous value.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         prev  <= 1'b1;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   // Edge flag; a new edge wins over a clear in the same cycle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag <= 1'b0;
      end else if (edge_hit) begin
         flag <= 1'b1;
      end else if (ack || sense == saeic_pkg::SENSE_LOW) begin
         flag <= 1'b0;
      end
   end

   assign req   = (sense == saeic_pkg::SENSE_LOW)  ? ~sync2 :
                  (sense == saeic_pkg::SENSE_RSVD) ? 1'b0   : flag;
   assign level = sync2;

   a_edge_detect: assert property (@(posedge clk) disable iff (reset)
      (sense == saeic_pkg::SENSE_FALL) && fall |=>
      (sense != saeic_pkg::SENSE_FALL) || req)
      else $error("falling edge gave no request");
   a_rsvd_sense: assert property (@(posedge clk) disable iff (reset)
      sense == saeic_pkg::SENSE_RSVD |-> !req)
      else $error("reserved sense raised a request");
   a_level_req: assert property (@(posedge clk) disable iff (reset)
      sense == saeic_pkg::SENSE_LOW && !sync2 |-> req)
      else $error("low level without request");
   c_edge_seen: cover property (@(posedge clk) disable iff (reset)
      (sense == saeic_pkg::SENSE_RISE) && rise ##1 req);
endmodule

// ==== verif/saeic_irq_src.sv ====
// Behavioural external sources that drive the two interrupt pins.
`timescale 1ns/1ps
module saeic_irq_src (
   // Clock.
   input  wire logic clk,
   // Requests from the bench to pull a pin low.
   input  wire logic hold_a,
   input  wire logic hold_b,
   // Pins; a released pin returns to its pull-up level.
   output logic      pin_a,
   output logic      pin_b
);
   // low level held
   // A source holds its pin low exactly as long as asked, so level waits rest on the bench.
   always_ff @(posedge clk) begin
      pin_a <= ~hold_a;
      pin_b <= ~hold_b;
   end
endmodule

// ==== verif/sleep_and_ext_irq_control_bench.sv ====
// Self-checking bench for the sleep and external interrupt control block.
`timescale 1ns/1ps
module sleep_and_ext_irq_control_bench;
   logic        clk = 1'b0, reset = 1'b1;    // Clock and reset.
   logic [9:0]  address = 10'h000;           // Bus request.
   logic [3:0]  byteenable = 4'h0;
   logic        read = 1'b0, write = 1'b0;
   logic [31:0] writedata = 32'h0, readdata;
   logic        waitrequest;
   logic        halt = 1'b0, ack_a = 1'b0;   // Core handshake.
   logic        pend = 1'b0, hold_a = 1'b0, hold_b = 1'b0;
   logic        pin_a, pin_b, take_a, take_b;
   logic        cpu_en, per_en, osc_en, comp_en;
   logic        instr_done = 1'b0, t2_ovf = 1'b0, t2_run;  // Core and timer events.
   int          num_errors = 0, total_checks = 0, cycles = 0;
   logic [7:0]  ctl = saeic_pkg::IDX_MCU_CONTROL, aux = saeic_pkg::IDX_AUX_CONTROL;

   // The clock toggles every 12.5 ns, half of its 25 ns period.
   always #12.5 clk = ~clk;

   saeic_irq_src u_src (.clk(clk), .hold_a(hold_a), .hold_b(hold_b), .pin_a(pin_a),
      .pin_b(pin_b));
   saeic_top u_dut (.CLK(clk), .RESET(reset), .ADDRESS(address), .BYTEENABLE(byteenable),
      .READ(read), .WRITE(write), .WRITEDATA(writedata), .READDATA(readdata),
      .WAITREQUEST(waitrequest), .HALT_EXEC(halt), .INSTR_DONE(instr_done), .IRQ_ACK_A(ack_a),
      .IRQ_ACK_B(1'b0), .EXT_IRQ_PIN_A(pin_a), .EXT_IRQ_PIN_B(pin_b), .INT_IRQ_PEND(pend),
      .COMP_IRQ(1'b0), .T2_OVF_IRQ(t2_ovf), .T2_CMP_IRQ(1'b0), .IRQ_TAKE_A(take_a),
      .IRQ_TAKE_B(take_b), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .OSC_EN(osc_en),
      .COMP_PWR_EN(comp_en), .T2_ASYNC_RUN(t2_run));

   // Prints the counts and the verdict, then stops the run.
   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Compares a value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon access: held until a rising edge sees waitrequest low, answered and released there.
   task automatic bus(input bit wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      address <= {idx, 2'h0};
      byteenable <= 4'hF;
      writedata <= wd;
      write <= wr;
      read <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0);
   endtask

   // Register write and checked register read.
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, i, d, x);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, i, 32'h0, x);
      chk(x, e);
   endtask

   // Waits n edges and lands between edges where outputs are settled.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // One halt pulse from the core; the answer shows one cycle later.
   task automatic do_halt();
      @(posedge clk);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      @(negedge clk);
   endtask

   // A hang counts as a mismatch and ends the run.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("ERROR at %0t: timeout", $time);
         tally_and_finish();
      end
   end

   // Main sequence of scenarios.
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rdc(ctl, 32'h0);
      rdc(aux, 32'h0);
      wr(ctl, 32'hFFFFFFFF);
      rdc(ctl, 32'h7F);
      rdc(8'h10, 32'h0);
      wr(aux, 32'h08);
      cyc(1);
      chk({31'h0, comp_en}, 32'h0);
      // Falling edge on the first pin, acknowledged.
      wr(ctl, 32'h02);
      wr(aux, 32'h03);
      @(posedge clk) hold_a <= 1'b1;
      repeat (2) @(posedge clk);
      hold_a <= 1'b0;
      cyc(6);
      chk({31'h0, take_a}, 32'h1);
      @(posedge clk) ack_a <= 1'b1;
      @(posedge clk) ack_a <= 1'b0;
      cyc(1);
      chk({31'h0, take_a}, 32'h0);
      // Low level on the second pin, first without the global enable.
      wr(aux, 32'h04);
      @(posedge clk) hold_b <= 1'b1;
      cyc(5);
      chk({31'h0, take_b}, 32'h0);
      wr(aux, 32'h05);
      cyc(10);
      chk({31'h0, take_b}, 32'h1);
      wr(ctl, 32'h06);
      cyc(2);
      chk({31'h0, take_b}, 32'h0);
      @(posedge clk) hold_b <= 1'b0;
      // Halt without the arm bit, then idle, then reserved select.
      wr(ctl, 32'h00);
      do_halt();
      chk({31'h0, cpu_en}, 32'h1);
      wr(ctl, 32'h40);
      do_halt();
      chk({30'h0, cpu_en, per_en}, 32'h1);
      @(posedge clk) pend <= 1'b1;
      @(posedge clk) pend <= 1'b0;
      @(negedge clk);
      chk({31'h0, cpu_en}, 32'h1);
      wr(ctl, 32'h50);
      do_halt();
      chk({31'h0, cpu_en}, 32'h1);
      // Power-down woken by a held low level on the first pin.
      wr(aux, 32'h03);
      wr(ctl, 32'h60);
      do_halt();
      chk({30'h0, cpu_en, osc_en}, 32'h0);
      @(posedge clk) hold_a <= 1'b1;
      cyc(saeic_pkg::STARTUP_CYCLES_I - 10);
      chk({31'h0, cpu_en}, 32'h0);
      cyc(40);
      chk({30'h0, cpu_en, take_a}, 32'h3);
      @(posedge clk) hold_a <= 1'b0;
      // Power save woken by the timer with the global enable clear.
      wr(aux, 32'h30);
      wr(ctl, 32'h70);
      do_halt();
      chk({29'h0, cpu_en, osc_en, t2_run}, 32'h1);
      @(posedge clk) t2_ovf <= 1'b1;
      @(posedge clk) t2_ovf <= 1'b0;
      cyc(saeic_pkg::STARTUP_CYCLES_I + 5);
      chk({31'h0, cpu_en}, 32'h1);
      rdc(saeic_pkg::IDX_STATUS, 32'h10);
      @(posedge clk) instr_done <= 1'b1;
      repeat (2) @(posedge clk);
      instr_done <= 1'b0;
      rdc(saeic_pkg::IDX_STATUS, 32'h10);
      @(posedge clk) instr_done <= 1'b1;
      @(posedge clk) instr_done <= 1'b0;
      rdc(saeic_pkg::IDX_STATUS, 32'h0);
      // Reset while in idle wakes the block with cleared registers.
      wr(ctl, 32'h40);
      do_halt();
      chk({31'h0, cpu_en}, 32'h0);
      @(posedge clk) reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      cyc(2);
      chk({31'h0, cpu_en}, 32'h1);
      rdc(ctl, 32'h0);
      tally_and_finish();
   end
endmodule
